/* design/pload_host.sv */
// Host end: divides the system clock into the load clock and paces data words.
// Assumes the user holds words steady while word_valid_i waits for word_ready_o.
`timescale 1ns/1ps
`default_nettype none
module pload_host
	import pload_pkg::*;
(
	input  wire logic                  ref_clk_i,     // System clock
	input  wire logic                  rstn_i,        // Sync reset, low
	input  wire pload_pkg::load_width_e width_i,      // Load width
	input  wire logic                  decomp_i,      // Decompression on
	input  wire logic                  secure_i,      // Security on
	input  wire logic [31:0]           word_i,        // Word to send
	input  wire logic                  word_valid_i,  // Word offered
	input  wire logic                  word_last_i,   // Final word
	output logic                       word_ready_o,  // Word taken
	output logic                       busy_o,        // Clock running
	pload_if.host                      link           // Load link
);
	import pload_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_RUN  = 2'h1,
		H_TAIL = 2'h2
	} host_state_e;

	host_state_e        state_q;
	logic [7:0]         div_q;
	logic               clk_q;
	logic [RATIO_W-1:0] phase_q;
	logic [RATIO_W-1:0] ratio;
	logic [31:0]        data_q;
	logic               last_q;
	logic               fall;
	logic               slot;

	assign ratio = load_ratio(width_i, decomp_i, secure_i);
	assign fall  = clk_q && (div_q == HALF_CNT - 8'h1);
	// In H_RUN, new data only on the falling edge that closes a group's last cycle; H_IDLE takes the first word with the clock low
	assign slot  = fall && (phase_q == ratio - 4'h1);
	assign word_ready_o = (state_q == H_IDLE) || (state_q == H_RUN && slot && !last_q);
	assign busy_o = (state_q != H_IDLE);
	assign link.load_clock = clk_q;
	assign link.data       = data_q;

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			state_q <= H_IDLE;
			div_q   <= 8'h0;
			clk_q   <= 1'b0;
			phase_q <= 4'h0;
			data_q  <= 32'h0;
			last_q  <= 1'b0;
		end else begin
			case (state_q)
				H_IDLE: begin
					div_q   <= 8'h0;
					clk_q   <= 1'b0;
					phase_q <= 4'h0;
					if (word_valid_i) begin
						data_q  <= word_i & lane_mask(width_i);
						last_q  <= word_last_i;
						state_q <= H_RUN;
					end
				end
				H_RUN, H_TAIL: begin
					if (div_q == HALF_CNT - 8'h1) begin
						div_q <= 8'h0;
						clk_q <= !clk_q;
						if (clk_q) begin
							phase_q <= (phase_q == ratio - 4'h1) ? 4'h0 : phase_q + 4'h1;
						end
					end else begin
						div_q <= div_q + 8'h1;
					end
					// After the last word's group, stop (ratio-1 extra cycles run)
					if (slot && last_q) begin
						state_q <= H_IDLE;
					end else if (slot && word_valid_i) begin
						data_q <= word_i & lane_mask(width_i);
						last_q <= word_last_i;
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* include/pload_pkg.sv */
// Constants shared by both ends of the parallel configuration load link.
// Assumes both ends run on a common 20 MHz system clock; the load clock is made by the host.
// What this block does
// - Byte mode: ratio 1, or 2 with decompression
// - Word modes: 16 gives 1/2/4, 32 gives 1/4/8
// - Host clocks ratio times data rate, paces data
// - Device uses surplus cycles to decrypt, decompress
// - Byte mode uses data lines 7 to 0
// - Half-word mode uses data lines 15 to 0
// - Host keeps clocking ratio minus one after last
package pload_pkg;

	typedef enum logic [1:0] {
		WIDTH_8  = 2'h0,
		WIDTH_16 = 2'h1,
		WIDTH_32 = 2'h2
	} load_width_e;

	localparam int unsigned DATA_W      = 32;
	localparam int unsigned RATIO_W     = 4;
	localparam int unsigned CLK_FREQ_HZ = 20000000;
	// Load clock half period in system clocks (host divider)
	localparam int unsigned HALF_PERIOD = 4;
	localparam logic [7:0]  HALF_CNT    = 8'(HALF_PERIOD);

	// Clock-per-word ratio for a width and option pair
	function automatic logic [RATIO_W-1:0] load_ratio(input load_width_e w,
		input logic decomp, input logic secure);
		logic [RATIO_W-1:0] r;
		r = 4'h1;
		case (w)
			WIDTH_8:  r = decomp ? 4'h2 : 4'h1;
			WIDTH_16: r = decomp ? 4'h4 : (secure ? 4'h2 : 4'h1);
			WIDTH_32: r = decomp ? 4'h8 : (secure ? 4'h4 : 4'h1);
			default:  r = 4'h1;
		endcase
		return r;
	endfunction

	// Lanes that carry data for a width
	function automatic logic [DATA_W-1:0] lane_mask(input load_width_e w);
		logic [DATA_W-1:0] m;
		m = 32'hFFFFFFFF;
		case (w)
			WIDTH_8:  m = 32'h000000FF;
			WIDTH_16: m = 32'h0000FFFF;
			WIDTH_32: m = 32'hFFFFFFFF;
			default:  m = 32'hFFFFFFFF;
		endcase
		return m;
	endfunction

endpackage

/* include/pload_if.sv */
// Link between the configuration host and the loading device.
// Assumes the bench instantiates one and connects both modports.
`timescale 1ns/1ps
`default_nettype none
interface pload_if;
	logic        load_clock;
	logic [31:0] data;

	modport host (output load_clock, output data);
	modport dev  (input load_clock, input data);
endinterface
`default_nettype wire

/* design/pload_dev.sv */
// Device end: samples the load clock, latches a word per ratio group, then
// spends the remaining cycles of the group on a stand-in decode pipeline.
// Assumes the host keeps the ratio-1 trailing cycles after the last word.
`timescale 1ns/1ps
`default_nettype none
module pload_dev
	import pload_pkg::*;
(
	input  wire logic                  ref_clk_i,   // System clock
	input  wire logic                  rstn_i,      // Sync reset, low
	input  wire pload_pkg::load_width_e width_i,    // Load width
	input  wire logic                  decomp_i,    // Decompression on
	input  wire logic                  secure_i,    // Security on
	input  wire logic [31:0]           key_i,       // Decrypt key
	pload_if.dev                       link,        // Load link
	output logic [31:0]                cfg_word_o,  // Decoded word
	output logic                       cfg_valid_o  // Word pulse
);
	import pload_pkg::*;

	logic [2:0]         clk_sync_q;
	logic [31:0]        data_s1_q;
	logic [31:0]        data_s2_q;
	logic [RATIO_W-1:0] phase_q;
	logic [RATIO_W-1:0] ratio;
	logic [31:0]        work_q;
	logic               pend_q;
	logic [31:0]        word_q;
	logic               valid_q;
	logic               rise;
	logic               first;
	logic               group_end;
	logic [31:0]        step;

	assign ratio = load_ratio(width_i, decomp_i, secure_i);
	// Edge found after two sync stages only
	assign rise  = clk_sync_q[1] && !clk_sync_q[2];
	assign first = rise && (phase_q == 4'h0);
	assign group_end = rise && (phase_q == ratio - 4'h1);
	// One stand-in decode step per surplus rise, the closing rise included
	assign step = (secure_i ? (work_q ^ key_i) : work_q) ^
		(decomp_i ? {work_q[30:0], work_q[31]} : 32'h0);
	assign cfg_word_o  = word_q;
	assign cfg_valid_o = valid_q;

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			clk_sync_q <= 3'h0;
			data_s1_q  <= 32'h0;
			data_s2_q  <= 32'h0;
			phase_q    <= 4'h0;
			work_q     <= 32'h0;
			pend_q     <= 1'b0;
			word_q     <= 32'h0;
			valid_q    <= 1'b0;
		end else begin
			clk_sync_q <= {clk_sync_q[1:0], link.load_clock};
			data_s1_q  <= link.data;
			data_s2_q  <= data_s1_q;
			valid_q    <= 1'b0;
			if (rise) begin
				phase_q <= (phase_q == ratio - 4'h1) ? 4'h0 : phase_q + 4'h1;
			end
			if (first) begin
				work_q <= data_s2_q & lane_mask(width_i);
				pend_q <= 1'b1;
			end else if (rise && pend_q) begin
				// Surplus cycles: one decode step per load-clock rise
				work_q <= step;
			end
			// Word is ready when its group closes; why the tail cycles matter
			if (group_end && (pend_q || first)) begin
				word_q  <= first ? (data_s2_q & lane_mask(width_i)) : step;
				valid_q <= 1'b1;
				pend_q  <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/pload_properties.sv */
// Link checker: load clock shape, data pacing, lane use.
// Assumes the bench feeds it the link and the shared mode inputs.
`timescale 1ns/1ps
`default_nettype none
module pload_properties
	import pload_pkg::*;
(
	input wire logic        ref_clk_i,  // Clock
	input wire logic        rstn_i,     // Reset, low
	input wire load_width_e width_i,    // Width
	input wire logic        decomp_i,   // Decomp
	input wire logic        secure_i,   // Secure
	input wire logic        load_clock, // Link clock
	input wire logic [31:0] data        // Link data
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	logic [31:0] data_q;
	logic [7:0]  gap_q;
	wire         chg = data != data_q;
	wire [3:0]   ratio = width_i == WIDTH_8 ? (decomp_i ? 4'h2 : 4'h1) :
		width_i == WIDTH_16 ? (decomp_i ? 4'h4 : secure_i ? 4'h2 : 4'h1) :
		(decomp_i ? 4'h8 : secure_i ? 4'h4 : 4'h1);
	wire [7:0]   min_gap = {1'b0, ratio, 3'h0} - 8'h01;
	// Saturated at reset so the first word is never flagged
	always_ff @(posedge ref_clk_i) begin
		data_q <= data;
		gap_q  <= !rstn_i ? 8'hFF : chg ? 8'h00 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
	end
	sequence s_high;
		load_clock [*4] ##1 !load_clock;
	endsequence
	property p_lanes8; width_i == WIDTH_8 |-> data[31:8] == 24'h0; endproperty
	a_lanes8: assert property (p_lanes8) else $error("upper lanes used in byte mode");
	property p_lanes16; width_i == WIDTH_16 |-> data[31:16] == 16'h0; endproperty
	a_lanes16: assert property (p_lanes16) else $error("upper lanes used in half mode");
	property p_high; $rose(load_clock) |-> s_high; endproperty
	a_high: assert property (p_high) else $error("load clock high phase wrong");
	property p_low; $fell(load_clock) |-> !load_clock [*4]; endproperty
	a_low: assert property (p_low) else $error("load clock low phase short");
	property p_rate; $rose(load_clock) |=> !$rose(load_clock) [*7]; endproperty
	a_rate: assert property (p_rate) else $error("load clock too fast");
	property p_ratio; chg |-> gap_q >= min_gap; endproperty
	a_ratio: assert property (p_ratio) else $error("data changed inside group");
	property p_data_low; chg |-> !load_clock; endproperty
	a_data_low: assert property (p_data_low) else $error("data changed while clock high");
	property p_reset; disable iff (1'b0) !rstn_i |=> !load_clock && data == 32'h0; endproperty
	a_reset: assert property (p_reset) else $error("link not idle after reset");
endmodule
`default_nettype wire

/* tb/parallel_config_loader_test.sv */
// Bench: host and device joined by the link, every width and option pair.
// Assumes inputs change on the falling edge of a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module parallel_config_loader_test;
	import pload_pkg::*;
	logic        ref_clk_i = 0;
	logic        rstn_i = 0;
	load_width_e width_i = WIDTH_8;
	logic        decomp_i = 0;
	logic        secure_i = 0;
	logic [31:0] word_i = 0;
	logic        word_valid_i = 0;
	logic        word_last_i = 0;
	logic        word_ready_o, busy_o, cfg_valid_o;
	logic [31:0] cfg_word_o;
	logic [31:0] key = 32'h5A5A0FF0;
	logic [31:0] got[$];
	int          num_errors = 0;
	int          n_checks = 0;
	pload_if link_if();
	pload_host pload_host_inst(.ref_clk_i, .rstn_i, .width_i, .decomp_i, .secure_i, .word_i,
		.word_valid_i, .word_last_i, .word_ready_o, .busy_o, .link(link_if));
	pload_dev pload_dev_inst(.ref_clk_i, .rstn_i, .width_i, .decomp_i, .secure_i,
		.key_i(key), .link(link_if), .cfg_word_o, .cfg_valid_o);
	pload_properties pload_properties_inst(.ref_clk_i, .rstn_i, .width_i, .decomp_i,
		.secure_i, .load_clock(link_if.load_clock), .data(link_if.data));
	initial forever #25 ref_clk_i = ~ref_clk_i;
	always @(negedge ref_clk_i) if (cfg_valid_o === 1'b1) got.push_back(cfg_word_o);
	function automatic logic [31:0] wd(input int i);
		return 32'hC3A55A3C + 32'(i) * 32'h01230123;
	endfunction
	// Stand-in decode applied once per surplus load-clock cycle
	function automatic logic [31:0] dec(input logic [31:0] d, input int n, input logic dc,
		input logic sc);
		logic [31:0] v;
		v = d;
		for (int k = 1; k < n; k++) v = (sc ? v ^ key : v) ^ (dc ? {v[30:0], v[31]} : 32'h0);
		return v;
	endfunction
	task automatic conclude(input bit to);
		if (to) num_errors++;
		if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		n_checks++;
		if (act !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, act, exp);
		end
	endtask
	// Word held until ready seen settled, taken at the next rise
	task automatic put(input logic [31:0] d, input logic l);
		int t;
		@(negedge ref_clk_i);
		word_i = d;
		word_valid_i = 1;
		word_last_i = l;
		for (t = 0; t < 600; t++) begin
			#1;
			if (word_ready_o === 1'b1) break;
			@(negedge ref_clk_i);
		end
		if (t == 600) conclude(1);
		@(posedge ref_clk_i);
	endtask
	task automatic run(input load_width_e w, input logic dc, input logic sc);
		logic [31:0] m;
		int r;
		int t;
		@(negedge ref_clk_i);
		rstn_i = 0;
		width_i = w;
		decomp_i = dc;
		secure_i = sc;
		repeat (3) @(negedge ref_clk_i);
		got.delete();
		rstn_i = 1;
		for (int i = 0; i < 3; i++) put(wd(i), i == 2);
		@(negedge ref_clk_i);
		word_valid_i = 0;
		for (t = 0; t < 900 && busy_o !== 1'b0; t++) @(negedge ref_clk_i);
		if (t == 900) conclude(1);
		repeat (8) @(negedge ref_clk_i);
		m = w == WIDTH_8 ? 32'hFF : w == WIDTH_16 ? 32'hFFFF : 32'hFFFFFFFF;
		// Ratio per width and options, then ratio minus one decode steps
		r = w == WIDTH_8 ? (dc ? 2 : 1) : w == WIDTH_16 ? (dc ? 4 : sc ? 2 : 1) :
			(dc ? 8 : sc ? 4 : 1);
		chk(32'(got.size()), 32'h3);
		for (int i = 0; i < got.size(); i++) chk(got[i], dec(wd(i) & m, r, dc, sc));
	endtask
	initial begin
		for (int w = 0; w < 3; w++)
			for (int o = 0; o < 4; o++)
				run(load_width_e'(w), o[1], o[0]);
		conclude(0);
	end
endmodule
`default_nettype wire
